/* File: hw/pmpc_pkg.sv */
// constants, types and code tables for the phy mode, power and crossover control block
// assumes a single 40 MHz clock; line cells arrive already recovered from the analogue front end
//
// Summary of operation
// - at 10M, bit 19.0 powers 100M modules down
// - at 100M, bit 19.1 powers 10M modules down
// - control bit 0.12 enables auto-negotiation
// - negotiation picks highest common partner mode
// - 100M: 4B/5B, NRZI, MLT-3, scrambled serial data
// - 10M: serialise nibbles with Manchester coding
// - full duplex: transmit and receive run independently
// - 10M full duplex: no loopback, no SQE test
// - full duplex: CRS from receive only, COL low
// - no link: swap pairs when crossover enabled
// - pin or field 19.9:8 disables crossover
// - crossover resolves before negotiation starts
// - half duplex: CRS on either, COL on overlap
package pmpc_pkg;
  // ===========================================================
  // sizes
  localparam int FIFO_WIDTH = 4;
  localparam int FIFO_DEPTH = 8;
  // ===========================================================
  // timing
  localparam int CLK_NS = 25;
  localparam int XOVER_NS = 60000;
  localparam int XOVER_CYCLES = XOVER_NS / CLK_NS;
  localparam int SQE_NS = 1000;
  localparam int SQE_CYCLES = SQE_NS / CLK_NS;
  localparam logic [11:0] XOVER_LAST = 12'(XOVER_CYCLES - 1);
  localparam logic [5:0] SQE_LAST = 6'(SQE_CYCLES - 1);
  // line cell spacing in clocks minus one, model rate only
  localparam logic [2:0] CELL_DIV_100 = 3'h0;
  localparam logic [2:0] CELL_DIV_10 = 3'h3;
  // last cell index of one nibble on the line
  localparam logic [2:0] TX_LAST_100 = 3'h4;
  localparam logic [2:0] TX_LAST_10 = 3'h7;
  localparam logic [2:0] RX_LAST_100 = 3'h4;
  localparam logic [2:0] RX_LAST_10 = 3'h7;
  // ===========================================================
  // crossover control field values
  localparam logic [1:0] XOVER_AUTO = 2'h0;
  localparam logic [1:0] XOVER_MDIX = 2'h2;
  // ===========================================================
  // ability bit positions, highest index is the best mode
  localparam int ABIL_10HD = 0;
  localparam int ABIL_10FD = 1;
  localparam int ABIL_100HD = 2;
  localparam int ABIL_100FD = 3;
  localparam logic [3:0] LOCAL_ABILITY = 4'hf;
  // ===========================================================
  // scrambler x^11 + x^9 + 1 and MLT-3 levels
  localparam logic [10:0] LFSR_SEED = 11'h7ff;
  localparam int LFSR_TAP_A = 10;
  localparam int LFSR_TAP_B = 8;
  localparam logic [1:0] MLT_ZERO = 2'h0;
  localparam logic [1:0] MLT_POS = 2'h1;
  localparam logic [1:0] MLT_NEG = 2'h3;

  typedef enum logic [1:0] {ST_XOVER, ST_NEG, ST_UP} pmpc_state_e;

  // 4B/5B data code groups, first line bit in bit 4
  function automatic logic [4:0] pmpc_enc(input logic [3:0] nib);
    logic [4:0] s;
    case (nib)
      4'h0: s = 5'h1e;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0a;
      4'h5: s = 5'h0b;
      4'h6: s = 5'h0e;
      4'h7: s = 5'h0f;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'ha: s = 5'h16;
      4'hb: s = 5'h17;
      4'hc: s = 5'h1a;
      4'hd: s = 5'h1b;
      4'he: s = 5'h1c;
      default: s = 5'h1d;
    endcase
    return s;
  endfunction

  // inverse table search; a non-data group decodes to zero
  function automatic logic [3:0] pmpc_dec(input logic [4:0] sym);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (pmpc_enc(4'(i)) == sym) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction
endpackage

/* File: hw/pmpc_stream_if.sv */
// valid/ready stream carrier between the control block and its fifo
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface pmpc_stream_if #(parameter int W = 4);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // pmpc_stream_if
`default_nettype wire

/* File: hw/pmpc_fifo.sv */
// synchronous fifo of flip-flops with valid/ready on both sides
// assumes the drain side may stall at any time; in-side ready is registered
`timescale 1ns/100ps
`default_nettype none
module pmpc_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input wire logic mclk, // system clock
  input wire logic reset, // async reset, high
  pmpc_stream_if.snk wr, // filling side
  pmpc_stream_if.src rd // draining side
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // ===========================================================
  // handshakes
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;
  assign rd.valid = (count != '0);
  assign rd.data = mem[rp];
  assign next_count = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});

  // occupancy and pointers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count <= '0;
      wp <= '0;
      rp <= '0;
    end else begin
      count <= next_count;
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : AW'(wp + 1'b1);
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : AW'(rp + 1'b1);
      end
    end
  end

  // registered ready keeps the combinational path off the source
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr.ready <= 1'b1;
    end else begin
      wr.ready <= (next_count < (AW+1)'(DEPTH));
    end
  end

  // one storage word per entry
  for (genvar e = 0; e < DEPTH; e++) begin : g_mem
    always_ff @(posedge mclk) begin
      if (push && wp == AW'(e)) begin
        mem[e] <= wr.data;
      end
    end
  end
endmodule // pmpc_fifo
`default_nettype wire

/* File: hw/pmpc_ctrl.sv */
// top of the mode, power-saving and crossover control with the mac and line data paths
// assumes mac side and line cell strobes are synchronous to mclk; the analogue front end
// recovers line cells and reports energy, and management bits arrive as plain levels
`timescale 1ns/100ps
`default_nettype none
module pmpc_ctrl
  import pmpc_pkg::*;
(
  input wire logic mclk, // 40 MHz system clock
  input wire logic reset, // async reset, high
  input wire logic [3:0] mac_txd, // transmit nibble
  input wire logic mac_tx_valid, // transmit enable, nibble valid
  output logic mac_tx_ready, // fifo can take a nibble
  output logic [3:0] mac_rxd, // received nibble
  output logic mac_rx_dv, // one-cycle strobe per received nibble
  output logic mac_crs, // carrier sense
  output logic mac_col, // collision
  output logic [1:0] line_tx_mlt, // 100M transmit level
  output logic line_tx_manch, // 10M transmit cell
  output logic line_tx_en, // transmit cell strobe
  input wire logic [1:0] line_rx_mlt, // 100M receive level
  input wire logic line_rx_manch, // 10M receive cell
  input wire logic line_rx_valid, // receive cell strobe
  input wire logic line_rx_active, // frame on receive pair
  input wire logic line_energy, // link signal detected
  input wire logic [3:0] partner_ability, // partner mode bits
  input wire logic partner_valid, // partner page received
  input wire logic an_enable, // negotiation enable, 0.12
  input wire logic forced_speed100, // forced speed when negotiation off
  input wire logic forced_full, // forced duplex when negotiation off
  input wire logic psave_100_off, // 19.0
  input wire logic psave_10_off, // 19.1
  input wire logic [1:0] crossover_ctrl, // 19.9:8
  input wire logic crossover_auto_enable_pin, // pin, high enables auto
  output logic mdix_active, // pairs swapped
  output logic link_up, // link established
  output logic speed100, // resolved speed
  output logic full_duplex, // resolved duplex
  output logic mod100_enable, // 100M modules powered
  output logic mod10_enable // 10M modules powered
);
  pmpc_stream_if #(.W(FIFO_WIDTH)) tx_in ();
  pmpc_stream_if #(.W(FIFO_WIDTH)) tx_out ();

  pmpc_state_e state;
  logic [11:0] xover_cnt;
  logic xover_on;
  logic [2:0] cell_cnt;
  logic cell_tick;
  logic tx_busy;
  logic [4:0] tx_sym;
  logic [2:0] tx_idx;
  logic [2:0] tx_last;
  logic tx_load;
  logic tx_bit100;
  logic tx_bit10;
  logic tx_cell10;
  logic [10:0] tx_lfsr;
  logic tx_scr;
  logic [1:0] mlt_phase;
  logic [1:0] next_mlt_phase;
  logic tx_act;
  logic tx_act_d;
  logic [5:0] sqe_cnt;
  logic sqe_on;
  logic loop_on;
  logic rx_cell_v;
  logic rx_cell;
  logic rx_act;
  logic [1:0] rx_prev_mlt;
  logic [10:0] rx_lfsr;
  logic [4:0] rx_shift;
  logic [2:0] rx_idx;
  logic [2:0] rx_last;
  logic rx_bit100;
  logic [3:0] common;

  // ===========================================================
  // transmit fifo
  assign tx_in.valid = mac_tx_valid;
  assign tx_in.data = mac_txd;
  assign mac_tx_ready = tx_in.ready;

  pmpc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .wr(tx_in),
    .rd(tx_out)
  );

  // ===========================================================
  // link sequencing: crossover, then negotiation, then link
  // pin or field disables
  assign xover_on = crossover_auto_enable_pin && (crossover_ctrl == XOVER_AUTO);
  assign common = LOCAL_ABILITY & partner_ability;

  // mode sequencer
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= ST_XOVER;
      link_up <= 1'b0;
      speed100 <= 1'b0;
      full_duplex <= 1'b0;
    end else begin
      case (state)
        ST_XOVER: begin
          if (!xover_on || line_energy) begin
            state <= ST_NEG;
          end
        end
        ST_NEG: begin
          // energy lost before link with crossover enabled: back to the pair hunt
          if (xover_on && !line_energy) begin
            state <= ST_XOVER;
          end else if (!an_enable) begin
            speed100 <= forced_speed100;
            full_duplex <= forced_full;
            link_up <= 1'b1;
            state <= ST_UP;
          end else if (partner_valid) begin
            if (common[ABIL_100FD]) begin
              speed100 <= 1'b1;
              full_duplex <= 1'b1;
            end else if (common[ABIL_100HD]) begin
              speed100 <= 1'b1;
              full_duplex <= 1'b0;
            end else if (common[ABIL_10FD]) begin
              speed100 <= 1'b0;
              full_duplex <= 1'b1;
            end else begin
              speed100 <= 1'b0;
              full_duplex <= 1'b0;
            end
            // nothing in common means no link, restart the hunt
            link_up <= (common != 4'h0);
            state <= (common != 4'h0) ? ST_UP : ST_XOVER;
          end
        end
        ST_UP: begin
          if (!line_energy) begin
            link_up <= 1'b0;
            state <= ST_XOVER;
          end
        end
        default: begin
          link_up <= 1'b0;
          state <= ST_XOVER;
        end
      endcase
    end
  end

  // pair assignment; a swap only while hunting keeps a working pair once link is seen
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mdix_active <= 1'b0;
      xover_cnt <= '0;
    end else if (!xover_on) begin
      mdix_active <= (crossover_ctrl == XOVER_MDIX);
      xover_cnt <= '0;
    end else if (state == ST_XOVER && !line_energy) begin
      if (xover_cnt == XOVER_LAST) begin
        xover_cnt <= '0;
        mdix_active <= ~mdix_active;
      end else begin
        xover_cnt <= 12'(xover_cnt + 1'b1);
      end
    end else begin
      xover_cnt <= '0;
    end
  end

  // ===========================================================
  // power saving: unused speed modules off only when asked
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mod100_enable <= 1'b1;
      mod10_enable <= 1'b1;
    end else begin
      mod100_enable <= !(link_up && !speed100 && psave_100_off);
      mod10_enable <= !(link_up && speed100 && psave_10_off);
    end
  end

  // ===========================================================
  // line cell timing, reduced model rate
  assign cell_tick = (cell_cnt == 3'h0);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cell_cnt <= 3'h0;
    end else if (cell_tick) begin
      cell_cnt <= speed100 ? CELL_DIV_100 : CELL_DIV_10;
    end else begin
      cell_cnt <= 3'(cell_cnt - 1'b1);
    end
  end

  // ===========================================================
  // transmit serialiser
  assign tx_last = speed100 ? TX_LAST_100 : TX_LAST_10;
  assign tx_load = cell_tick && (!tx_busy || tx_idx == tx_last);
  assign tx_out.ready = tx_load;
  assign tx_bit100 = tx_sym[3'(TX_LAST_100 - tx_idx)];
  assign tx_bit10 = tx_sym[tx_idx[2:1]];
  // Manchester: inverted half then true half
  assign tx_cell10 = tx_idx[0] ? tx_bit10 : ~tx_bit10;
  assign tx_scr = tx_bit100 ^ tx_lfsr[LFSR_TAP_A];
  assign next_mlt_phase = tx_scr ? 2'(mlt_phase + 1'b1) : mlt_phase;

  // nibble load and cell index
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_busy <= 1'b0;
      tx_sym <= 5'h00;
      tx_idx <= 3'h0;
    end else if (tx_load) begin
      tx_busy <= tx_out.valid;
      tx_idx <= 3'h0;
      if (tx_out.valid) begin
        tx_sym <= speed100 ? pmpc_enc(tx_out.data) : {1'b0, tx_out.data};
      end
    end else if (cell_tick && tx_busy) begin
      tx_idx <= 3'(tx_idx + 1'b1);
    end
  end

  // line drive; scrambler runs only on 100M cells so both ends stay aligned per frame
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_lfsr <= LFSR_SEED;
      mlt_phase <= 2'h0;
      line_tx_mlt <= MLT_ZERO;
      line_tx_manch <= 1'b0;
      line_tx_en <= 1'b0;
    end else begin
      line_tx_en <= cell_tick && tx_busy;
      if (!tx_busy) begin
        tx_lfsr <= LFSR_SEED;
      end else if (cell_tick && speed100) begin
        tx_lfsr <= {tx_lfsr[9:0], tx_lfsr[LFSR_TAP_A] ^ tx_lfsr[LFSR_TAP_B]};
        mlt_phase <= next_mlt_phase;
        case (next_mlt_phase)
          2'h1: line_tx_mlt <= MLT_POS;
          2'h3: line_tx_mlt <= MLT_NEG;
          default: line_tx_mlt <= MLT_ZERO;
        endcase
      end else if (cell_tick) begin
        line_tx_manch <= tx_cell10;
      end
    end
  end

  // ===========================================================
  // receive path
  // loopback only in 10M half duplex
  assign loop_on = !speed100 && !full_duplex && tx_busy && !line_rx_active;
  assign rx_cell_v = loop_on ? (cell_tick && tx_busy) : line_rx_valid;
  assign rx_cell = loop_on ? tx_cell10 : line_rx_manch;
  assign rx_act = line_rx_active || loop_on;
  assign rx_last = speed100 ? RX_LAST_100 : RX_LAST_10;
  // MLT-3 change is a one, then descramble
  assign rx_bit100 = (line_rx_mlt != rx_prev_mlt) ^ rx_lfsr[LFSR_TAP_A];

  // deserialiser and decoders
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_prev_mlt <= MLT_ZERO;
      rx_lfsr <= LFSR_SEED;
      rx_shift <= 5'h00;
      rx_idx <= 3'h0;
      mac_rxd <= 4'h0;
      mac_rx_dv <= 1'b0;
    end else begin
      mac_rx_dv <= 1'b0;
      if (!rx_act) begin
        rx_lfsr <= LFSR_SEED;
        rx_idx <= 3'h0;
        rx_prev_mlt <= line_rx_mlt;
      end else if (rx_cell_v) begin
        rx_idx <= (rx_idx == rx_last) ? 3'h0 : 3'(rx_idx + 1'b1);
        if (speed100) begin
          rx_prev_mlt <= line_rx_mlt;
          rx_lfsr <= {rx_lfsr[9:0], rx_lfsr[LFSR_TAP_A] ^ rx_lfsr[LFSR_TAP_B]};
          rx_shift <= {rx_shift[3:0], rx_bit100};
          if (rx_idx == rx_last) begin
            mac_rxd <= pmpc_dec({rx_shift[3:0], rx_bit100});
            mac_rx_dv <= 1'b1;
          end
        end else if (rx_idx[0] == 1'b0) begin
          // first half cell carries the inverted bit
          rx_shift[rx_idx[2:1]] <= ~rx_cell;
        end else if (rx_idx == rx_last) begin
          mac_rxd <= rx_shift[3:0];
          mac_rx_dv <= 1'b1;
        end
      end
    end
  end

  // ===========================================================
  // carrier sense, collision and heartbeat test
  assign tx_act = mac_tx_valid || tx_out.valid || tx_busy;

  // heartbeat after each 10M half duplex transmission
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_act_d <= 1'b0;
      sqe_on <= 1'b0;
      sqe_cnt <= 6'h00;
    end else begin
      tx_act_d <= tx_act;
      if (tx_act_d && !tx_act && !speed100 && !full_duplex) begin
        sqe_on <= 1'b1;
        sqe_cnt <= 6'h00;
      end else if (sqe_on) begin
        sqe_on <= (sqe_cnt != SQE_LAST);
        sqe_cnt <= 6'(sqe_cnt + 1'b1);
      end
    end
  end

  // mii status pins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mac_crs <= 1'b0;
      mac_col <= 1'b0;
    end else if (full_duplex) begin
      mac_crs <= line_rx_active;
      mac_col <= 1'b0;
    end else begin
      mac_crs <= tx_act || line_rx_active;
      mac_col <= (tx_act && line_rx_active) || sqe_on;
    end
  end
endmodule // pmpc_ctrl
`default_nettype wire

/* File: test/pmpc_ctrl_properties.sv */
// concurrent checks on the ports of the mode, power and crossover control top
// assumes one clock domain, mclk, with reset asynchronous and active high
`timescale 1ns/100ps
`default_nettype none
module pmpc_ctrl_properties
  import pmpc_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic reset, // async reset
  input wire logic mac_tx_valid, // tx enable
  input wire logic mac_crs, // carrier sense
  input wire logic mac_col, // collision
  input wire logic line_rx_active, // rx frame
  input wire logic line_energy, // link signal
  input wire logic psave_100_off, // 19.0
  input wire logic psave_10_off, // 19.1
  input wire logic [1:0] crossover_ctrl, // 19.9:8
  input wire logic crossover_auto_enable_pin, // auto pin
  input wire logic mdix_active, // pairs swapped
  input wire logic link_up, // link
  input wire logic speed100, // speed
  input wire logic full_duplex, // duplex
  input wire logic mod100_enable, // 100M power
  input wire logic mod10_enable // 10M power
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic auto_on;
  logic [12:0] hunt_cnt;
  // ===========================================================
  // hunt timer: cycles without a swap while no link and no energy
  assign auto_on = crossover_auto_enable_pin && crossover_ctrl == XOVER_AUTO;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hunt_cnt <= 13'h0;
    end else if (link_up || line_energy || !auto_on || $changed(mdix_active)) begin
      hunt_cnt <= 13'h0;
    end else begin
      hunt_cnt <= hunt_cnt + 13'h1;
    end
  end
  // ===========================================================
  // duplex status; a changed duplex gets one cycle to settle
  fd_col_quiet_a: assert property (
    full_duplex && $past(full_duplex) |-> !mac_col) else $error("collision in full duplex");
  fd_crs_rx_a: assert property (
    full_duplex && $past(full_duplex) |-> mac_crs == $past(line_rx_active)) else $error("crs not rx");
  hd_col_both_a: assert property (
    link_up && !full_duplex && mac_tx_valid && line_rx_active |=> mac_col) else $error("no collision");
  hd_crs_any_a: assert property (
    link_up && !full_duplex && (mac_tx_valid || line_rx_active) |=> mac_crs) else $error("no crs");
  // power saving follows the management bits while linked
  psave_100_a: assert property (
    link_up && !speed100 |=> mod100_enable == !$past(psave_100_off)) else $error("100M power wrong");
  psave_10_a: assert property (
    link_up && speed100 |=> mod10_enable == !$past(psave_10_off)) else $error("10M power wrong");
  // crossover: forced setting, hold at link, bounded hunt, link only after energy
  xover_forced_a: assert property (
    !auto_on |=> mdix_active == ($past(crossover_ctrl) == XOVER_MDIX)) else $error("forced pairs wrong");
  xover_hold_a: assert property (
    link_up && auto_on |=> $stable(mdix_active)) else $error("swap while linked");
  hunt_bound_a: assert property (
    hunt_cnt <= 13'h965) else $error("no swap while hunting");
  link_gate_a: assert property (
    $rose(link_up) && auto_on && $past(auto_on, 4) |-> $past(line_energy)) else $error("link before pairs");
  cover property (link_up && mdix_active);
  cover property (mac_col && !full_duplex);
  cover property (!mod100_enable || !mod10_enable);
endmodule // pmpc_ctrl_properties

bind pmpc_ctrl pmpc_ctrl_properties u_props (.mclk, .reset, .mac_tx_valid, .mac_crs, .mac_col,
  .line_rx_active, .line_energy, .psave_100_off, .psave_10_off, .crossover_ctrl, .crossover_auto_enable_pin,
  .mdix_active, .link_up, .speed100, .full_duplex, .mod100_enable, .mod10_enable);
`default_nettype wire

/* File: test/pmpc_peer.sv */
// model of the remote link partner and of the receive side of the line
// assumes a crossed cable: energy arrives only while the block has its pairs swapped
`timescale 1ns/100ps
`default_nettype none
module pmpc_peer (
  input wire logic mclk, // clock
  input wire logic reset, // async reset
  input wire logic peer_on, // partner powered and cabled
  input wire logic [3:0] ability, // partner modes
  input wire logic mdix_active, // block pair swap
  output logic line_energy, // link signal seen
  output logic [3:0] partner_ability, // advertised modes
  output logic partner_valid, // page received
  output logic line_rx_manch = 1'b0, // 10M rx cell
  output logic line_rx_valid = 1'b0, // rx cell strobe
  output logic line_rx_active = 1'b0 // rx frame
);
  logic [3:0] page_cnt;
  // energy only on the wired pairing
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      line_energy <= 1'b0;
      page_cnt <= 4'h0;
    end else begin
      line_energy <= peer_on && mdix_active;
      page_cnt <= !line_energy ? 4'h0 : page_cnt + {3'h0, page_cnt != 4'hf};
    end
  end
  // the page is garbage until it has been received
  assign partner_valid = page_cnt > 4'h7;
  assign partner_ability = partner_valid ? ability : ~ability;
  // one nibble, bit 0 first, inverted half then true half
  task automatic send_nib(input logic [3:0] nib);
    line_rx_active = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      #1;
      line_rx_manch = nib[i/2] ^ ~i[0];
      line_rx_valid = 1'b1;
      @(posedge mclk);
      #1;
      line_rx_valid = 1'b0;
      line_rx_manch = ~line_rx_manch; // no stale cell between strobes
      repeat (2) @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    #1;
    line_rx_active = 1'b0;
  endtask
endmodule // pmpc_peer
`default_nettype wire

/* File: test/tb_phy_mode_power_crossover_ctrl.sv */
// self-checking bench for the mode, power and crossover control block
// assumes the peer model drives the line side and the cable needs a pair swap
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module tb_phy_mode_power_crossover_ctrl;
  logic mclk = 1'b0, reset = 1'b1, mac_tx_valid = 1'b0, an_enable = 1'b0, forced_speed100 = 1'b0;
  logic forced_full = 1'b1, psave_100_off = 1'b0, psave_10_off = 1'b0, crossover_auto_enable_pin = 1'b1;
  logic peer_on = 1'b0, mac_tx_ready, mac_rx_dv, mac_crs, mac_col, line_tx_manch, line_tx_en;
  logic line_rx_manch, line_rx_valid, line_rx_active, line_energy, partner_valid, mdix_active, link_up;
  logic speed100, full_duplex, mod100_enable, mod10_enable;
  logic [3:0] mac_txd = 4'h0, ability = 4'hf, mac_rxd, partner_ability;
  logic [1:0] crossover_ctrl = 2'h0, line_tx_mlt;
  logic [3:0] xt [4] = '{4'hb, 4'h6, 4'he, 4'h0}; // {field, pin, swapped}
  logic [5:0] nt [4] = '{6'h3f, 6'h16, 6'h0d, 6'h04}; // {offer, speed100, full}
  int mismatches, samples_checked, cells, dvs, acc, cols;
  logic rdy;

  pmpc_ctrl u_dut (.mclk, .reset, .mac_txd, .mac_tx_valid, .mac_tx_ready, .mac_rxd, .mac_rx_dv, .mac_crs,
    .mac_col, .line_tx_mlt, .line_tx_manch, .line_tx_en, .line_rx_mlt(2'h0), .line_rx_manch, .line_rx_valid,
    .line_rx_active, .line_energy, .partner_ability, .partner_valid, .an_enable, .forced_speed100,
    .forced_full, .psave_100_off, .psave_10_off, .crossover_ctrl, .crossover_auto_enable_pin, .mdix_active,
    .link_up, .speed100, .full_duplex, .mod100_enable, .mod10_enable);
  pmpc_peer u_peer (.mclk, .reset, .peer_on, .ability, .mdix_active, .line_energy, .partner_ability,
    .partner_valid, .line_rx_manch, .line_rx_valid, .line_rx_active);

  // ===========================================================
  // clock, line and receive monitors
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (line_tx_en === 1'b1) cells++;
    if (mac_rx_dv === 1'b1) dvs++;
    if (mac_col === 1'b1 && line_rx_active === 1'b1) cols++;
  end

  // ===========================================================
  // access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // hold a nibble until taken or limit cycles pass; refused cycles are retried, so acc counts takes
  task automatic send(input int n, input int limit);
    acc = 0;
    mac_tx_valid = 1'b1;
    for (int i = 0; i < limit && acc < n; i++) begin
      mac_txd = 4'(acc + 5);
      // ready is settled before the edge; reading it at the edge would race its flop
      rdy = mac_tx_ready;
      @(posedge mclk);
      #1;
      if (rdy === 1'b1) acc++;
    end
    mac_tx_valid = 1'b0;
  endtask
  task automatic wait_link(input logic want);
    for (int i = 0; i < 6000 && link_up !== want; i++) tick(1);
    `CHK("link_up", want, link_up)
  endtask
  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ===========================================================
  // watchdog, far above the expected run
  initial begin
    #1500000;
    mismatches++;
    close_out;
  end

  initial begin
    tick(12);
    reset = 1'b0;
    peer_on = 1'b1;
    tick(100);
    `CHK("link_early", 1'b0, link_up)
    wait_link(1'b1);
    `CHK("mdix_active", 1'b1, mdix_active)
    `CHK("forced_mode", 2'h1, {speed100, full_duplex})
    // fill the fifo at 10M full duplex, drain it, no loopback
    dvs = 0;
    cells = 0;
    send(12, 12);
    `CHK("fifo_refused", 1'b1, acc >= 8 && acc < 12)
    tick(acc * 32 + 40);
    `CHK("tx_cells_10", acc * 8, cells)
    `CHK("tx_ready", 1'b1, mac_tx_ready)
    `CHK("rx_loopback", 0, dvs)
    // pin or field turns the hunt off
    foreach (xt[i]) begin
      {crossover_ctrl, crossover_auto_enable_pin} = xt[i][3:1];
      tick(3);
      `CHK("mdix_forced", xt[i][0], mdix_active)
    end
    crossover_auto_enable_pin = 1'b1;
    wait_link(1'b1);
    an_enable = 1'b1;
    // best common mode for each partner offer, then power and cells
    foreach (nt[i]) begin
      ability = nt[i][5:2];
      peer_on = 1'b0;
      wait_link(1'b0);
      peer_on = 1'b1;
      wait_link(1'b1);
      `CHK("mode", nt[i][1:0], {speed100, full_duplex})
      `CHK("mods_on", 2'h3, {mod100_enable, mod10_enable})
      psave_100_off = 1'b1;
      psave_10_off = 1'b1;
      tick(3);
      `CHK("mod100_enable", nt[i][1], mod100_enable)
      `CHK("mod10_enable", !nt[i][1], mod10_enable)
      psave_100_off = 1'b0;
      psave_10_off = 1'b0;
      cells = 0;
      send(3, 100);
      tick(150);
      `CHK("tx_cells", nt[i][1] ? 15 : 24, cells)
    end
    // a received 10M nibble reaches the mac
    dvs = 0;
    u_peer.send_nib(4'ha);
    `CHK("rx_dv", 1, dvs)
    `CHK("mac_rxd", 4'ha, mac_rxd)
    cols = 0;
    fork
      send(2, 40);
      u_peer.send_nib(4'h3);
    join
    tick(60);
    `CHK("col_seen", 1'b1, cols > 0)
    close_out;
  end
endmodule // tb_phy_mode_power_crossover_ctrl
`default_nettype wire
